// ### rtl/cvb_cfg.svh
`ifndef CVB_CFG_SVH
`define CVB_CFG_SVH

// Valve count and word widths
`define CVB_NV 13
`define CVB_DW 16
`define CVB_AW 8
`define CVB_DUR_W 12
`define CVB_TICK_W 20

// Command word layout
`define CVB_OP_HI 15
`define CVB_OP_LO 12
`define CVB_OP_ENABLE 4'h1
`define CVB_OP_DURATION 4'h2
`define CVB_OP_AUX 4'h3
`define CVB_OPEN_HI 15
`define CVB_OPEN_LO 13
`define CVB_OPEN_PREFIX 3'h6
`define CVB_PAIR_CMD 16'hE000
`define CVB_PAIR_MASK 13'h1800
`define CVB_AUX_EN12_BIT 0
`define CVB_AUX_DIS_LO 1
`define CVB_AUX_DIS_HI 2

// Addresses
`define CVB_ADDR_WRITE 8'h00
`define CVB_ADDR_POS_NOW 8'h01
`define CVB_ADDR_POS_HIST 8'h02
`define CVB_ADDR_CUR_NOW 8'h03
`define CVB_ADDR_CUR_HIST 8'h04
`define CVB_ADDR_ENABLE 8'h05
`define CVB_ADDR_DURATION 8'h06
`define CVB_ADDR_AUX 8'h07

// Relief valve position in enable order
`define CVB_RELIEF_BIT 10

// Timing
`define CVB_TICK_NS 10000000
`define CVB_CLK_NS 25

`endif

// ### rtl/cvb_pkg.sv
package cvb_pkg;
`include "cvb_cfg.svh"

    typedef struct packed {
        logic wr;
        logic rd;
        logic [`CVB_AW-1:0] addr;
        logic [`CVB_DW-1:0] data;
    } cvb_bus_req_t;

    typedef struct packed {
        logic rvalid;
        logic [`CVB_DW-1:0] rdata;
    } cvb_bus_rsp_t;

    typedef struct packed {
        logic [`CVB_NV-1:0] flag_s1;
        logic [`CVB_NV-1:0] flag_s2;
        logic [`CVB_NV-1:0] flag_prev;
        logic [`CVB_NV-1:0] amp_s1;
        logic [`CVB_NV-1:0] amp_s2;
        logic [`CVB_NV-1:0] amp_prev;
        logic [1:0] press_s1;
        logic [1:0] press_s2;
        logic [`CVB_NV-1:0] enable;
        logic [`CVB_DUR_W-1:0] duration;
        logic [1:0] press_dis;
        logic [`CVB_NV-1:0] pos_hist;
        logic [`CVB_NV-1:0] cur_hist;
        logic [`CVB_NV-1:0][`CVB_DUR_W-1:0] cnt;
        logic [`CVB_TICK_W-1:0] tick_cnt;
        logic [`CVB_NV-1:0] supply_sw;
        logic [`CVB_NV-1:0] open_sw;
        cvb_bus_rsp_t rsp;
    } cvb_state_t;

endpackage

// ### rtl/cvb_valve_board.sv
`timescale 1ns/10ps
`include "cvb_cfg.svh"

module cvb_valve_board
    import cvb_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `CVB_TICK_NS / `CVB_CLK_NS
)
(
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input cvb_bus_req_t bus_req_i,
    output cvb_bus_rsp_t bus_rsp_o,
    input wire logic [`CVB_NV-1:0] valve_flag_i,
    input wire logic [`CVB_NV-1:0] valve_amp_i,
    input wire logic vessel_pressure_sensor_a_i,
    input wire logic vessel_pressure_sensor_b_i,
    output logic [`CVB_NV-1:0] supply_sw_o,
    output logic [`CVB_NV-1:0] open_sw_o
);

    // Open-command bit to enable-bit order
    function automatic logic [`CVB_NV-1:0] remap_open(input logic [`CVB_NV-1:0] c);
        logic [`CVB_NV-1:0] e;
        e = c;
        e[0] = c[0];
        e[1] = c[1];
        e[4] = c[2];
        e[5] = c[3];
        e[2] = c[4];
        e[6] = c[5];
        e[3] = c[6];
        e[7] = c[7];
        return e;
    endfunction

    logic rst_s1_q;
    logic rst_n_q;
    cvb_state_t s_q;
    cvb_state_t s_d;
    logic wr_cmd;
    logic rd_cmd;
    logic open_cmd;
    logic tick;
    logic trip;
    logic [`CVB_NV-1:0] open_sel;
    logic [`CVB_NV-1:0] pos_rise;
    logic [`CVB_NV-1:0] cur_rise;
    logic [`CVB_NV-1:0] cnt_nz;
    logic [3:0] opcode;

    // Reset released through two flops so release is clean
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    assign opcode = bus_req_i.data[`CVB_OP_HI:`CVB_OP_LO];
    assign wr_cmd = bus_req_i.wr && (bus_req_i.addr == `CVB_ADDR_WRITE);
    assign rd_cmd = bus_req_i.rd;
    assign tick = (s_q.tick_cnt == `CVB_TICK_W'(TICK_CYCLES - 1));
    assign pos_rise = s_q.flag_s2 & ~s_q.flag_prev;
    assign cur_rise = s_q.amp_s2 & ~s_q.amp_prev;
    assign trip = |(s_q.press_s2 & ~s_q.press_dis);

    always_comb
    begin
        open_cmd = 1'b0;
        open_sel = '0;
        if (wr_cmd && bus_req_i.data == `CVB_PAIR_CMD)
        begin
            open_cmd = 1'b1;
            open_sel = `CVB_PAIR_MASK;
        end
        else if (wr_cmd && bus_req_i.data[`CVB_OPEN_HI:`CVB_OPEN_LO] == `CVB_OPEN_PREFIX
                 && $onehot(bus_req_i.data[`CVB_NV-1:0]))
        begin
            open_cmd = 1'b1;
            open_sel = remap_open(bus_req_i.data[`CVB_NV-1:0]);
        end
    end

    always_comb
    begin
        for (int v = 0; v < `CVB_NV; v++)
        begin
            cnt_nz[v] = (s_q.cnt[v] != '0);
        end
    end

    always_comb
    begin
        s_d = s_q;
        // Pins cross in through two flops before use
        s_d.flag_s1 = valve_flag_i;
        s_d.flag_s2 = s_q.flag_s1;
        s_d.flag_prev = s_q.flag_s2;
        s_d.amp_s1 = valve_amp_i;
        s_d.amp_s2 = s_q.amp_s1;
        s_d.amp_prev = s_q.amp_s2;
        s_d.press_s1 = {vessel_pressure_sensor_b_i, vessel_pressure_sensor_a_i};
        s_d.press_s2 = s_q.press_s1;

        // Free-running prescaler; first step of an open may be short
        if (tick)
        begin
            s_d.tick_cnt = '0;
        end
        else
        begin
            s_d.tick_cnt = s_q.tick_cnt + `CVB_TICK_W'(1);
        end

        if (wr_cmd && opcode == `CVB_OP_ENABLE)
        begin
            s_d.enable[`CVB_NV-2:0] = bus_req_i.data[`CVB_NV-2:0];
        end
        if (wr_cmd && opcode == `CVB_OP_DURATION)
        begin
            s_d.duration = bus_req_i.data[`CVB_DUR_W-1:0];
        end
        if (wr_cmd && opcode == `CVB_OP_AUX)
        begin
            s_d.enable[`CVB_NV-1] = bus_req_i.data[`CVB_AUX_EN12_BIT];
            s_d.press_dis = bus_req_i.data[`CVB_AUX_DIS_HI:`CVB_AUX_DIS_LO];
        end

        for (int v = 0; v < `CVB_NV; v++)
        begin
            if (!s_q.enable[v])
            begin
                s_d.cnt[v] = '0;
            end
            else if (open_cmd && open_sel[v] && s_q.duration != '0)
            begin
                s_d.cnt[v] = s_q.duration;
            end
            else if (tick && cnt_nz[v])
            begin
                s_d.cnt[v] = s_q.cnt[v] - `CVB_DUR_W'(1);
            end
        end
        if (open_cmd)
        begin
            // Refused opens still consume the duration
            s_d.duration = '0;
        end

        // History: a new transition beats a same-cycle clearing read
        s_d.pos_hist = s_q.pos_hist | pos_rise;
        s_d.cur_hist = s_q.cur_hist | cur_rise;
        if (rd_cmd && bus_req_i.addr == `CVB_ADDR_POS_HIST)
        begin
            s_d.pos_hist = pos_rise;
        end
        if (rd_cmd && bus_req_i.addr == `CVB_ADDR_CUR_HIST)
        begin
            s_d.cur_hist = cur_rise;
        end

        s_d.supply_sw = s_q.enable;
        s_d.open_sw = cnt_nz & s_q.enable;
        if (trip)
        begin
            // Relief path bypasses enable and duration entirely
            s_d.supply_sw[`CVB_RELIEF_BIT] = 1'b1;
            s_d.open_sw[`CVB_RELIEF_BIT] = 1'b1;
        end

        s_d.rsp.rvalid = rd_cmd;
        s_d.rsp.rdata = '0;
        if (rd_cmd)
        begin
            unique case (bus_req_i.addr)
                `CVB_ADDR_POS_NOW: s_d.rsp.rdata = `CVB_DW'(s_q.flag_s2);
                `CVB_ADDR_POS_HIST: s_d.rsp.rdata = `CVB_DW'(s_q.pos_hist);
                `CVB_ADDR_CUR_NOW: s_d.rsp.rdata = `CVB_DW'(s_q.amp_s2);
                `CVB_ADDR_CUR_HIST: s_d.rsp.rdata = `CVB_DW'(s_q.cur_hist);
                `CVB_ADDR_ENABLE: s_d.rsp.rdata = `CVB_DW'(s_q.enable);
                `CVB_ADDR_DURATION: s_d.rsp.rdata = `CVB_DW'(s_q.duration);
                `CVB_ADDR_AUX: s_d.rsp.rdata = `CVB_DW'(s_q.press_dis);
                default: s_d.rsp.rdata = '0;
            endcase
        end
    end

    // Constant reset keeps both disables clear, so both triggers are live
    always_ff @(posedge core_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign bus_rsp_o = s_q.rsp;
    assign supply_sw_o = s_q.supply_sw;
    assign open_sw_o = s_q.open_sw;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_q);

    property p_enable_load;
        wr_cmd && opcode == `CVB_OP_ENABLE
        |=> s_q.enable[`CVB_NV-2:0] == $past(bus_req_i.data[`CVB_NV-2:0]);
    endproperty
    a_enable_load: assert property (p_enable_load)
        else $error("enable not loaded from write");

    property p_open_clears_duration;
        open_cmd |=> s_q.duration == '0;
    endproperty
    a_open_clears_duration: assert property (p_open_clears_duration)
        else $error("open command left duration nonzero");

    property p_zero_duration_refused;
        open_cmd && s_q.duration == '0 && cnt_nz == '0
        |=> cnt_nz == '0 ##1 (open_sw_o == '0 || $past(trip));
    endproperty
    a_zero_duration_refused: assert property (p_zero_duration_refused)
        else $error("open executed with zero duration");

    property p_disabled_ignored;
        open_cmd && (open_sel & ~s_q.enable) != '0
        |=> (cnt_nz & $past(open_sel & ~s_q.enable)) == '0;
    endproperty
    a_disabled_ignored: assert property (p_disabled_ignored)
        else $error("open executed on disabled valve");

    property p_open_loads;
        open_cmd && s_q.duration != '0 && (open_sel & s_q.enable) != '0
        |=> ##1 (open_sw_o & $past(open_sel & s_q.enable, 2)) == $past(open_sel & s_q.enable, 2);
    endproperty
    a_open_loads: assert property (p_open_loads)
        else $error("enabled valve did not open");

    property p_open_needs_supply;
        (open_sw_o & ~supply_sw_o) == '0;
    endproperty
    a_open_needs_supply: assert property (p_open_needs_supply)
        else $error("open switch on without supply");

    property p_history_latch;
        pos_rise != '0 |=> (s_q.pos_hist & $past(pos_rise)) == $past(pos_rise);
    endproperty
    a_history_latch: assert property (p_history_latch)
        else $error("position transition not latched");

    property p_read_clears;
        rd_cmd && bus_req_i.addr == `CVB_ADDR_CUR_HIST
        |=> s_q.cur_hist == $past(cur_rise) && bus_rsp_o.rdata == `CVB_DW'($past(s_q.cur_hist));
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("history read did not clear");

    property p_duration_readback;
        rd_cmd && bus_req_i.addr == `CVB_ADDR_DURATION
        |=> bus_rsp_o.rvalid && bus_rsp_o.rdata == `CVB_DW'($past(s_q.duration));
    endproperty
    a_duration_readback: assert property (p_duration_readback)
        else $error("duration readback wrong");

    property p_relief;
        trip |=> supply_sw_o[`CVB_RELIEF_BIT] && open_sw_o[`CVB_RELIEF_BIT];
    endproperty
    a_relief: assert property (p_relief)
        else $error("relief valve not forced open");

    property p_countdown;
        tick && cnt_nz[0] && s_q.enable[0] && !(open_cmd && open_sel[0])
        |=> s_q.cnt[0] == $past(s_q.cnt[0]) - `CVB_DUR_W'(1);
    endproperty
    a_countdown: assert property (p_countdown)
        else $error("open time did not count down");

    property p_duration_load;
        wr_cmd && opcode == `CVB_OP_DURATION
        |=> s_q.duration == $past(bus_req_i.data[`CVB_DUR_W-1:0]);
    endproperty
    a_duration_load: assert property (p_duration_load)
        else $error("duration not loaded from write");

    property p_supply_follows;
        !trip |=> supply_sw_o == $past(s_q.enable);
    endproperty
    a_supply_follows: assert property (p_supply_follows)
        else $error("supply switches differ from enable");

    property p_closed_when_idle;
        !trip && !cnt_nz[0] |=> !open_sw_o[0];
    endproperty
    a_closed_when_idle: assert property (p_closed_when_idle)
        else $error("valve open with no time left");

    property p_position_now;
        rd_cmd && bus_req_i.addr == `CVB_ADDR_POS_NOW
        |=> bus_rsp_o.rdata == `CVB_DW'($past(s_q.flag_s2));
    endproperty
    a_position_now: assert property (p_position_now)
        else $error("position status readback wrong");

    property p_position_read_clears;
        rd_cmd && bus_req_i.addr == `CVB_ADDR_POS_HIST
        |=> s_q.pos_hist == $past(pos_rise) && bus_rsp_o.rdata == `CVB_DW'($past(s_q.pos_hist));
    endproperty
    a_position_read_clears: assert property (p_position_read_clears)
        else $error("position history read did not clear");

endmodule // cvb_valve_board

// ### bench/cvb_host_model.sv
`timescale 1ns/10ps

module cvb_host_model
    import cvb_pkg::*;
(
    input wire logic core_clk_i,
    output cvb_bus_req_t bus_req_o,
    input cvb_bus_rsp_t bus_rsp_i
);
    initial bus_req_o = '0;

    // Durations stay in counts of ticks, 100 ns at the bench's TICK_CYCLES of 4; zero only when a refusal is wanted
    task automatic wr(input logic [15:0] word);
        @(negedge core_clk_i);
        bus_req_o.wr = 1'b1;
        bus_req_o.addr = 8'h00;
        bus_req_o.data = word;
        @(negedge core_clk_i);
        bus_req_o.wr = 1'b0;
        // Released data shows the inverse so a stale word never passes
        bus_req_o.data = ~word;
    endtask

    // Answer stands from the taking edge on, sampled mid-cycle
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
        @(negedge core_clk_i);
        bus_req_o.rd = 1'b1;
        bus_req_o.addr = a;
        @(negedge core_clk_i);
        v = bus_rsp_i.rvalid;
        d = bus_rsp_i.rdata;
        bus_req_o.rd = 1'b0;
        bus_req_o.addr = ~a;
    endtask
endmodule // cvb_host_model

// ### bench/cvb_valve_board_tb_top.sv
`timescale 1ns/10ps
`include "cvb_cfg.svh"

module cvb_valve_board_tb_top;
    import cvb_pkg::*;
    localparam int TCK = 4;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    cvb_bus_req_t req;
    cvb_bus_rsp_t rsp;
    logic [`CVB_NV-1:0] flag = '0;
    logic [`CVB_NV-1:0] amp = '0;
    logic press_a = 1'b0;
    logic press_b = 1'b0;
    logic [`CVB_NV-1:0] sup;
    logic [`CVB_NV-1:0] opn;
    int err_count = 0;
    int check_count = 0;
    int map [13] = '{0, 1, 4, 5, 2, 6, 3, 7, 8, 9, 10, 11, 12};
    int n;

    always #12.5 core_clk = ~core_clk;

    cvb_valve_board #(.TICK_CYCLES(TCK)) dut_u (.core_clk_i(core_clk), .arst_n_i(arst_n),
        .bus_req_i(req), .bus_rsp_o(rsp), .valve_flag_i(flag), .valve_amp_i(amp),
        .vessel_pressure_sensor_a_i(press_a), .vessel_pressure_sensor_b_i(press_b),
        .supply_sw_o(sup), .open_sw_o(opn));

    cvb_host_model host_u (.core_clk_i(core_clk), .bus_req_o(req), .bus_rsp_i(rsp));

    task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        host_u.rd(a, d, v);
        chk_pin({15'h0000, v}, 16'h0001, "rvalid");
        chk_pin(d, exp, "rdata");
    endtask

    task automatic idle(input int c);
        repeat (c) @(negedge core_clk);
    endtask

    // Bounded wait for every open switch to fall
    task automatic wait_closed();
        n = 0;
        while (opn != '0 && n < 40)
        begin
            idle(1);
            n++;
        end
    endtask

    task automatic tend(input string name);
        $display("test %s done, checks %0d", name, check_count);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #200us;
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        conclude();
    end

    initial
    begin
        repeat (16) @(negedge core_clk);
        arst_n = 1'b1;
        idle(4);
        chk_pin({3'h0, sup | opn}, 16'h0000, "switches after reset");
        for (int a = 1; a <= 8; a++) chk_reg(a[7:0], 16'h0000);
        tend("reset");
        host_u.wr(16'h1FFF);
        host_u.wr(16'h3001);
        idle(2);
        chk_pin({3'h0, sup}, 16'h1FFF, "supply");
        chk_reg(8'h05, 16'h1FFF);
        tend("enable");
        for (int i = 0; i < 13; i++)
        begin
            host_u.wr(16'h2005);
            chk_reg(8'h06, 16'h0005);
            host_u.wr(16'hC000 | (16'h0001 << i));
            idle(3);
            chk_pin({3'h0, opn}, 16'h0001 << map[i], "open map");
            chk_reg(8'h06, 16'h0000);
            wait_closed();
            chk_pin(16'(n >= 4 * TCK - 5 && n <= 5 * TCK), 16'h0001, "open time");
        end
        host_u.wr(16'h2005);
        host_u.wr(16'hE000);
        idle(3);
        chk_pin({3'h0, opn}, 16'h1800, "pair open");
        wait_closed();
        host_u.wr(16'hC001);
        idle(4);
        chk_pin({3'h0, opn}, 16'h0000, "zero duration");
        tend("open");
        host_u.wr(16'h1000);
        host_u.wr(16'h2005);
        host_u.wr(16'hC001);
        idle(4);
        chk_pin({3'h0, opn}, 16'h0000, "disabled valve");
        chk_pin({3'h0, sup}, 16'h1000, "supply low bits");
        chk_reg(8'h06, 16'h0000);
        host_u.wr(16'h1FFF);
        host_u.wr(16'h25DC);
        chk_reg(8'h06, 16'h05DC);
        host_u.wr(16'hC002);
        idle(3);
        chk_pin({3'h0, opn}, 16'h0002, "long open");
        host_u.wr(16'h1FFD);
        idle(3);
        chk_pin({3'h0, opn}, 16'h0000, "supply removed");
        tend("gating");
        flag = 13'h0A5A;
        amp = 13'h1111;
        idle(4);
        chk_reg(8'h01, 16'h0A5A);
        chk_reg(8'h02, 16'h0A5A);
        chk_reg(8'h02, 16'h0000);
        chk_reg(8'h03, 16'h1111);
        chk_reg(8'h04, 16'h1111);
        chk_reg(8'h04, 16'h0000);
        // Complement patterns so every flag and current pin toggles
        flag = 13'h15A5;
        amp = 13'h0EEE;
        idle(4);
        chk_reg(8'h01, 16'h15A5);
        chk_reg(8'h02, 16'h15A5);
        chk_reg(8'h03, 16'h0EEE);
        chk_reg(8'h04, 16'h0EEE);
        flag = '0;
        amp = '0;
        tend("status");
        host_u.wr(16'h1000);
        host_u.wr(16'h3000);
        press_a = 1'b1;
        idle(4);
        chk_pin({14'h0000, sup[10], opn[10]}, 16'h0003, "relief a");
        host_u.wr(16'h3002);
        idle(3);
        chk_pin({14'h0000, sup[10], opn[10]}, 16'h0000, "relief a masked");
        chk_reg(8'h07, 16'h0001);
        press_b = 1'b1;
        idle(4);
        chk_pin({14'h0000, sup[10], opn[10]}, 16'h0003, "relief b");
        host_u.wr(16'h3004);
        idle(3);
        chk_pin({14'h0000, sup[10], opn[10]}, 16'h0003, "relief a again");
        host_u.wr(16'h3006);
        idle(3);
        chk_pin({14'h0000, sup[10], opn[10]}, 16'h0000, "relief both masked");
        press_a = 1'b0;
        press_b = 1'b0;
        tend("pressure");
        host_u.wr(16'h1FFF);
        arst_n = 1'b0;
        idle(2);
        chk_pin({3'h0, sup | opn}, 16'h0000, "switches in reset");
        arst_n = 1'b1;
        idle(4);
        chk_reg(8'h07, 16'h0000);
        chk_reg(8'h05, 16'h0000);
        tend("reset again");
        conclude();
    end
endmodule // cvb_valve_board_tb_top
